// >>> hw/pbt_trigger.sv
// pc breakpoint match registers and one/two level trigger sequencer
// assumes supervisor and serial debug accesses arrive as one-cycle strobes on this clock
`timescale 1ns/1ps
module pbt_trigger
(
  input wire logic clock,
  input wire logic sys_rst,
  input pbt_pkg::pbt_reg_wr_t sup_wr,
  input pbt_pkg::pbt_reg_wr_t ser_wr,
  input wire logic ser_rd_valid,
  input wire logic [4:0] ser_rd_index,
  output logic ser_rd_ack,
  output logic [31:0] ser_rd_data,
  input pbt_pkg::pbt_core_obs_t core,
  input wire logic [31:0] data_match_value,
  input wire logic [31:0] data_ignore_mask,
  output logic trace_valid,
  output logic [3:0] debug_trace_outputs,
  output logic halt_req,
  output logic debug_irq_req,
  output logic [3:0] trigger_state_field
);

  // ===========================================
  // register write path
  function automatic logic hits(input pbt_pkg::pbt_reg_wr_t w, input logic [4:0] idx);
    hits = w.valid && (w.index == idx);
  endfunction : hits

  logic [31:0] pc_match_value;
  logic [31:0] pc_ignore_mask;
  logic [31:0] trigger_setup;
  pbt_pkg::pbt_reg_wr_t wr;
  logic setup_wr;

  // serial port wins a same-cycle collision: the host is the one debugging
  assign wr = ser_wr.valid ? ser_wr : sup_wr;
  assign setup_wr = hits(wr, pbt_pkg::IDX_TRIGGER_SETUP);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pc_ignore_mask <= pbt_pkg::RST_PC_IGNORE_MASK;
    else if (hits(wr, pbt_pkg::IDX_PC_IGNORE_MASK))
      pc_ignore_mask <= wr.data;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pc_match_value <= pbt_pkg::RST_PC_MATCH_VALUE;
    else if (hits(wr, pbt_pkg::IDX_PC_MATCH_VALUE))
      pc_match_value <= wr.data;
  end

  // reserved bits 15-14 never stored, so they read as zero
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      trigger_setup <= pbt_pkg::RST_TRIGGER_SETUP;
    else if (setup_wr)
      trigger_setup <= wr.data & ~pbt_pkg::SETUP_RSVD_MASK;
  end

  // ===========================================
  // serial read path
  // serial readback, mask is write only
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ser_rd_ack <= 1'b0;
      ser_rd_data <= 32'h00000000;
    end
    else
    begin
      ser_rd_ack <= ser_rd_valid;
      if (ser_rd_valid)
      begin
        if (ser_rd_index == pbt_pkg::IDX_PC_MATCH_VALUE)
          ser_rd_data <= pc_match_value;
        else if (ser_rd_index == pbt_pkg::IDX_TRIGGER_SETUP)
          ser_rd_data <= trigger_setup;
        else
          ser_rd_data <= 32'h00000000;
      end
    end
  end

  // ===========================================
  // pc compare and level evaluation
  logic pc_hit;
  pbt_pkg::pbt_level_cfg_t cfg [2];
  logic [1:0] level_hit;
  logic [1:0] action;

  assign pc_hit = ((core.pc ^ pc_match_value) & ~pc_ignore_mask) == 32'h00000000;
  assign cfg[0] = pbt_pkg::pbt_level_cfg_t'(trigger_setup[pbt_pkg::L1_HALF_LSB +: 16]);
  assign cfg[1] = pbt_pkg::pbt_level_cfg_t'(trigger_setup[pbt_pkg::L2_HALF_LSB +: 16]);
  assign action = trigger_setup[pbt_pkg::ACTION_LSB +: 2];

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_level
      pbt_level_eval u_eval
      (
        .clock(clock),
        .sys_rst(sys_rst),
        .cfg(cfg[g]),
        .core(core),
        .pc_hit(pc_hit),
        .data_match_value(data_match_value),
        .data_ignore_mask(data_ignore_mask),
        .hit(level_hit[g])
      );
    end
  endgenerate

  // ===========================================
  // trigger sequencer
  typedef enum logic [2:0]
  {
    ST_ARMED = 3'b001,
    ST_LEVEL2 = 3'b010,
    ST_FIRED = 3'b100
  } pbt_state_t;

  pbt_state_t state;
  pbt_state_t next_state;
  logic both_armed;
  logic step1;
  logic complete;
  logic [3:0] complete_code;

  assign both_armed = cfg[0].level_arm && cfg[1].level_arm;

  // with both levels armed, level two waits for level one
  always_comb
  begin
    next_state = state;
    step1 = 1'b0;
    complete = 1'b0;
    complete_code = pbt_pkg::TSTAT_NONE;
    unique case (state)
      ST_ARMED:
        if (both_armed)
        begin
          if (level_hit[0])
          begin
            step1 = 1'b1;
            next_state = ST_LEVEL2;
          end
        end
        else if (level_hit[0] || level_hit[1])
        begin
          complete = 1'b1;
          complete_code = level_hit[1] ? pbt_pkg::TSTAT_LEVEL2 : pbt_pkg::TSTAT_LEVEL1;
          next_state = ST_FIRED;
        end
      ST_LEVEL2:
        if (level_hit[1])
        begin
          complete = 1'b1;
          complete_code = pbt_pkg::TSTAT_LEVEL2;
          next_state = ST_FIRED;
        end
      ST_FIRED:
        next_state = ST_FIRED;
    endcase
  end

  // a setup write rearms; a trigger in that same cycle still lands
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      state <= ST_ARMED;
    else if (complete || step1)
      state <= next_state;
    else if (setup_wr)
      state <= ST_ARMED;
    else
      state <= next_state;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      trigger_state_field <= pbt_pkg::TSTAT_NONE;
    else if (complete)
      trigger_state_field <= complete_code;
    else if (step1)
      trigger_state_field <= pbt_pkg::TSTAT_LEVEL1;
    else if (setup_wr)
      trigger_state_field <= pbt_pkg::TSTAT_NONE;
  end

  // ===========================================
  // trigger response
  // trace always, action on the same edge
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      trace_valid <= 1'b0;
      debug_trace_outputs <= pbt_pkg::TSTAT_NONE;
      halt_req <= 1'b0;
      debug_irq_req <= 1'b0;
    end
    else
    begin
      trace_valid <= complete;
      if (complete)
        debug_trace_outputs <= complete_code;
      halt_req <= complete && (action == pbt_pkg::ACT_HALT);
      debug_irq_req <= complete && (action == pbt_pkg::ACT_IRQ);
    end
  end

  // ===========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  pc_compare_a: assert property (core.pc == pc_match_value |-> pc_hit)
    else $error("equal pc not matched");
  pc_mask_a: assert property (pc_ignore_mask == 32'hFFFFFFFF |-> pc_hit)
    else $error("fully masked pc did not match");
  mask_write_a: assert property (hits(sup_wr, pbt_pkg::IDX_PC_IGNORE_MASK)
                                 && !ser_wr.valid |=> pc_ignore_mask == $past(sup_wr.data))
    else $error("supervisor mask write lost");
  mask_hidden_a: assert property (ser_rd_index == pbt_pkg::IDX_PC_IGNORE_MASK
    && ser_rd_valid |=> ser_rd_ack && ser_rd_data == 32'h00000000)
    else $error("write only mask was readable");
  // write, one quiet cycle, then readback
  value_read_a: assert property (hits(ser_wr, pbt_pkg::IDX_PC_MATCH_VALUE)
                                 ##1 !hits(wr, pbt_pkg::IDX_PC_MATCH_VALUE)
                                 ##1 (ser_rd_valid && ser_rd_index == pbt_pkg::IDX_PC_MATCH_VALUE)
                                 |=> ser_rd_ack && ser_rd_data == $past(ser_wr.data, 3))
    else $error("match value readback wrong");
  serial_first_a: assert property (hits(ser_wr, pbt_pkg::IDX_PC_MATCH_VALUE)
    && sup_wr.valid |=> pc_match_value == $past(ser_wr.data))
    else $error("write collision kept the wrong word");
  half_split_a: assert property (cfg[1].level_arm == trigger_setup[pbt_pkg::L2_ARM_BIT]
                                 && cfg[0].level_arm == trigger_setup[pbt_pkg::L1_ARM_BIT])
    else $error("level halves misplaced");
  setup_clear_a: assert property (setup_wr && !complete && !step1
                                  |=> trigger_state_field == pbt_pkg::TSTAT_NONE
                                      && state == ST_ARMED)
    else $error("setup write did not clear state");
  halt_resp_a: assert property (complete && action == pbt_pkg::ACT_HALT
                                |=> halt_req && !debug_irq_req && trace_valid)
    else $error("halt response wrong");
  irq_resp_a: assert property (complete && action == pbt_pkg::ACT_IRQ
                               |=> debug_irq_req && !halt_req && trace_valid)
    else $error("interrupt response wrong");
  trace_only_a: assert property (complete && (action == pbt_pkg::ACT_TRACE
                                              || action == pbt_pkg::ACT_RSVD)
                                 |=> trace_valid && !halt_req && !debug_irq_req)
    else $error("trace only response did more");
  trace_code_a: assert property (complete
    |=> debug_trace_outputs == $past(complete_code))
    else $error("trace code not reported");
  disarmed_a: assert property (!cfg[0].level_arm && !cfg[1].level_arm
                               |-> !complete && !step1)
    else $error("trigger while disarmed");
  lone_level_a: assert property (state == ST_ARMED && !cfg[0].level_arm
    && level_hit[1] |=> trace_valid && trigger_state_field == pbt_pkg::TSTAT_LEVEL2)
    else $error("lone second level did not complete");
  two_level_a: assert property (state == ST_ARMED && both_armed && level_hit[0]
                                |=> !trace_valid && state == ST_LEVEL2
                                    && trigger_state_field == pbt_pkg::TSTAT_LEVEL1)
    else $error("first level completed a two level trigger");

  one_level_c: cover property (state == ST_ARMED && !both_armed && complete);
  two_level_c: cover property (state == ST_LEVEL2 ##[1:20] complete);
  halt_c: cover property (halt_req);
  rearm_c: cover property (state == ST_FIRED ##1 setup_wr);
  collide_c: cover property (ser_wr.valid && sup_wr.valid);

endmodule : pbt_trigger

// >>> hw/pbt_pkg.sv
// package for the pc breakpoint trigger block: indices, fields, codes
// assumes one processor clock and debug accesses already decoded to strobes
package pbt_pkg;

  // ===========================================
  // debug register indices
  localparam logic [4:0] IDX_PC_IGNORE_MASK = 5'h09;
  localparam logic [4:0] IDX_PC_MATCH_VALUE = 5'h08;
  localparam logic [4:0] IDX_TRIGGER_SETUP = 5'h07;

  // ===========================================
  // reset values and field positions
  localparam logic [31:0] RST_PC_IGNORE_MASK = 32'h00000000;
  localparam logic [31:0] RST_PC_MATCH_VALUE = 32'h00000000;
  localparam logic [31:0] RST_TRIGGER_SETUP = 32'h00000000;
  localparam logic [31:0] SETUP_RSVD_MASK = 32'h0000C000;
  localparam int ACTION_LSB = 30;
  localparam int L2_HALF_LSB = 16;
  localparam int L1_HALF_LSB = 0;
  localparam int L2_ARM_BIT = 29;
  localparam int L1_ARM_BIT = 13;

  // ===========================================
  // trigger response codes
  localparam logic [1:0] ACT_TRACE = 2'h0;
  localparam logic [1:0] ACT_HALT = 2'h1;
  localparam logic [1:0] ACT_IRQ = 2'h2;
  localparam logic [1:0] ACT_RSVD = 2'h3;

  // ===========================================
  // operand sizes on the local data bus
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // ===========================================
  // trigger state field and trace codes
  localparam logic [3:0] TSTAT_NONE = 4'h0;
  localparam logic [3:0] TSTAT_LEVEL1 = 4'h1;
  localparam logic [3:0] TSTAT_LEVEL2 = 4'h2;

  // ===========================================
  // carriers
  // one half of trigger_setup, msb first
  typedef struct packed {
    logic [1:0] top;
    logic level_arm;
    logic longword_lane_enable;
    logic low_word_lane_enable;
    logic high_word_lane_enable;
    logic byte0_lane_enable;
    logic byte1_lane_enable;
    logic byte2_lane_enable;
    logic byte3_lane_enable;
    logic data_invert;
    logic [2:0] addr_enables;
    logic pc_enable;
    logic pc_invert;
  } pbt_level_cfg_t;

  typedef struct packed {
    logic valid;
    logic [4:0] index;
    logic [31:0] data;
  } pbt_reg_wr_t;

  typedef struct packed {
    logic [31:0] pc;
    logic pc_valid;
    logic [31:0] data;
    logic data_valid;
    logic [1:0] addr_lo;
    logic [1:0] size;
  } pbt_core_obs_t;

endpackage : pbt_pkg

// >>> hw/pbt_level_eval.sv
// one trigger level: pc condition and data lane condition
// assumes core observation and comparator values come from the processor clock domain
`timescale 1ns/1ps
module pbt_level_eval
(
  input wire logic clock,
  input wire logic sys_rst,
  input pbt_pkg::pbt_level_cfg_t cfg,
  input pbt_pkg::pbt_core_obs_t core,
  input wire logic pc_hit,
  input wire logic [31:0] data_match_value,
  input wire logic [31:0] data_ignore_mask,
  output logic hit
);

  // ===========================================
  // data lane compare
  logic [31:0] diff;
  logic [6:0] lanes;
  logic data_en;
  logic lane_hit;
  logic pc_term;
  logic data_term;

  assign diff = (core.data ^ data_match_value) & ~data_ignore_mask;
  assign lanes = {cfg.longword_lane_enable, cfg.low_word_lane_enable,
                  cfg.high_word_lane_enable, cfg.byte0_lane_enable, cfg.byte1_lane_enable,
                  cfg.byte2_lane_enable, cfg.byte3_lane_enable};
  assign data_en = |lanes;

  always_comb
  begin
    lane_hit = 1'b0;
    unique case (core.size)
      pbt_pkg::SIZE_LONG:
        lane_hit = cfg.longword_lane_enable && (diff == 32'h00000000);
      pbt_pkg::SIZE_WORD:
        lane_hit = core.addr_lo[1] ? (cfg.low_word_lane_enable && diff[15:0] == 16'h0000)
                                   : (cfg.high_word_lane_enable && diff[31:16] == 16'h0000);
      pbt_pkg::SIZE_BYTE:
        unique case (core.addr_lo)
          2'h3: lane_hit = cfg.byte0_lane_enable && diff[7:0] == 8'h00;
          2'h2: lane_hit = cfg.byte1_lane_enable && diff[15:8] == 8'h00;
          2'h1: lane_hit = cfg.byte2_lane_enable && diff[23:16] == 8'h00;
          2'h0: lane_hit = cfg.byte3_lane_enable && diff[31:24] == 8'h00;
        endcase
      default:
        lane_hit = 1'b0;
    endcase
  end

  // ===========================================
  // level condition
  // pc used only when enabled
  assign pc_term = cfg.pc_enable ? (core.pc_valid && (pc_hit ^ cfg.pc_invert)) : 1'b1;
  assign data_term = data_en ? (core.data_valid && (lane_hit ^ cfg.data_invert)) : 1'b1;
  assign hit = cfg.level_arm && (cfg.pc_enable || data_en) && pc_term && data_term;

  // ===========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  pc_use_gate_a: assert property (!cfg.pc_enable && !data_en |-> !hit)
    else $error("level hit without any enabled condition");
  level_arm_gate_a: assert property (!cfg.level_arm |-> !hit)
    else $error("disarmed level hit");
  data_off_a: assert property (cfg.pc_enable && !data_en && !cfg.pc_invert
                               && cfg.level_arm && core.pc_valid |-> hit == pc_hit)
    else $error("pc only level ignores pc result");
  long_lane_a: assert property (core.size == pbt_pkg::SIZE_LONG
                                && !cfg.longword_lane_enable |-> !lane_hit)
    else $error("longword matched with lane off");
  low_byte_a: assert property (core.size == pbt_pkg::SIZE_BYTE && core.addr_lo == 2'h3
                               && cfg.byte0_lane_enable && core.data[7:0] == data_match_value[7:0]
                               |-> lane_hit)
    else $error("byte0 lane miss");
  high_word_a: assert property (core.size == pbt_pkg::SIZE_WORD && !core.addr_lo[1]
                                && cfg.high_word_lane_enable
                                && core.data[31:16] == data_match_value[31:16]
                                |-> lane_hit)
    else $error("high word lane miss");

endmodule : pbt_level_eval

// >>> test/pbt_far_side.sv
// far side model: processor core observation and debug register host
// assumes the trigger block samples all of these on the rising clock edge
`timescale 1ns/1ps
module pbt_far_side
(
  input wire logic clock,
  input wire logic ser_rd_ack,
  input wire logic [31:0] ser_rd_data,
  output pbt_pkg::pbt_reg_wr_t sup_wr,
  output pbt_pkg::pbt_reg_wr_t ser_wr,
  output logic ser_rd_valid,
  output logic [4:0] ser_rd_index,
  output pbt_pkg::pbt_core_obs_t core
);
  // ===========================================
  // idle lines
  initial
  begin
    sup_wr = '0;
    ser_wr = '0;
    ser_rd_valid = 1'b0;
    ser_rd_index = 5'h00;
    core = '0;
  end

  // ===========================================
  // register write, one strobe cycle on either port
  task automatic reg_write(input logic use_ser, input logic [4:0] idx, input logic [31:0] d);
    pbt_pkg::pbt_reg_wr_t w;
    w = '{valid: 1'b1, index: idx, data: d};
    @(posedge clock);
    #1;
    if (use_ser)
      ser_wr = w;
    else
      sup_wr = w;
    @(posedge clock);
    #1;
    // released lines carry junk, never the last word
    w = '{valid: 1'b0, index: ~idx, data: ~d};
    if (use_ser)
      ser_wr = w;
    else
      sup_wr = w;
  endtask : reg_write

  // ===========================================
  // serial read, answer one cycle after the strobe
  task automatic reg_read(input logic [4:0] idx, output logic [31:0] d, output logic ok);
    @(posedge clock);
    #1;
    ser_rd_valid = 1'b1;
    ser_rd_index = idx;
    @(posedge clock);
    #1;
    ser_rd_valid = 1'b0;
    ser_rd_index = ~idx;
    ok = ser_rd_ack;
    d = ser_rd_data;
  endtask : reg_read

  // ===========================================
  // one observed core cycle
  task automatic core_step(input logic [31:0] pc, input logic pv, input logic [31:0] dat,
      input logic dv, input logic [1:0] sz, input logic [1:0] al);
    @(posedge clock);
    #1;
    core = '{pc: pc, pc_valid: pv, data: dat, data_valid: dv, addr_lo: al, size: sz};
    @(posedge clock);
    #1;
    core = '{pc: ~pc, pc_valid: 1'b0, data: ~dat, data_valid: 1'b0, addr_lo: ~al, size: ~sz};
  endtask : core_step

  // disarm before loading
  // no interlocks in the block, so setup is cleared first
  task automatic load_pc(input logic [31:0] mask, input logic [31:0] val);
    reg_write(1'b0, pbt_pkg::IDX_TRIGGER_SETUP, 32'h00000000);
    reg_write(1'b0, pbt_pkg::IDX_PC_IGNORE_MASK, mask);
    reg_write(1'b1, pbt_pkg::IDX_PC_MATCH_VALUE, val);
  endtask : load_pc
endmodule : pbt_far_side

// >>> test/tb.sv
// testbench for the pc breakpoint trigger block
// assumes pbt_far_side drives all debug and core inputs
`timescale 1ns/1ps
module tb;
  logic clock;
  logic sys_rst;
  pbt_pkg::pbt_reg_wr_t sup_wr;
  pbt_pkg::pbt_reg_wr_t ser_wr;
  logic ser_rd_valid;
  logic [4:0] ser_rd_index;
  logic ser_rd_ack;
  logic [31:0] ser_rd_data;
  pbt_pkg::pbt_core_obs_t core;
  logic [31:0] data_match_value;
  logic [31:0] data_ignore_mask;
  logic trace_valid;
  logic [3:0] debug_trace_outputs;
  logic halt_req;
  logic debug_irq_req;
  logic [3:0] trigger_state_field;
  int num_errors;
  int compares;
  logic [1:0] cur_act;
  logic [3:0] last_code;
  int lane_bit [7] = '{12, 11, 10, 9, 8, 7, 6};
  logic [1:0] lane_sz [7] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1};
  logic [1:0] lane_al [7] = '{2'h0, 2'h2, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
  logic [31:0] lane_dat [7] = '{32'h11223344, 32'hFFFF3344, 32'h1122FFFF, 32'hFFFFFF44,
    32'hFFFF33FF, 32'hFF22FFFF, 32'h11FFFFFF};

  pbt_trigger i_pbt_trigger (.clock(clock), .sys_rst(sys_rst), .sup_wr(sup_wr),
    .ser_wr(ser_wr), .ser_rd_valid(ser_rd_valid), .ser_rd_index(ser_rd_index),
    .ser_rd_ack(ser_rd_ack), .ser_rd_data(ser_rd_data), .core(core),
    .data_match_value(data_match_value), .data_ignore_mask(data_ignore_mask),
    .trace_valid(trace_valid), .debug_trace_outputs(debug_trace_outputs),
    .halt_req(halt_req), .debug_irq_req(debug_irq_req),
    .trigger_state_field(trigger_state_field));

  pbt_far_side i_pbt_far_side (.clock(clock), .ser_rd_ack(ser_rd_ack),
    .ser_rd_data(ser_rd_data), .sup_wr(sup_wr), .ser_wr(ser_wr),
    .ser_rd_valid(ser_rd_valid), .ser_rd_index(ser_rd_index), .core(core));

  // ===========================================
  // clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ===========================================
  // checking helpers
  task automatic end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [4:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    i_pbt_far_side.reg_read(idx, d, ok);
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("[ERR] %0t read answer missing", $time);
      end_of_test();
    end
    else
      chk(d, exp, "read data");
  endtask : rd_chk

  task automatic setup(input logic [31:0] v);
    i_pbt_far_side.reg_write(1'b0, pbt_pkg::IDX_TRIGGER_SETUP, v);
    cur_act = v[31:30];
  endtask : setup

  // outputs one cycle after the observed core cycle
  task automatic trig(input logic [31:0] pc, input logic pv, input logic [31:0] dat,
      input logic dv, input logic [1:0] sz, input logic [1:0] al, input logic fire,
      input logic [3:0] st);
    logic [31:0] exp;
    i_pbt_far_side.core_step(pc, pv, dat, dv, sz, al);
    if (fire)
      last_code = st;
    exp = {21'h000000, fire, fire & (cur_act == pbt_pkg::ACT_HALT),
      fire & (cur_act == pbt_pkg::ACT_IRQ), last_code, st};
    chk({21'h000000, trace_valid, halt_req, debug_irq_req, debug_trace_outputs,
      trigger_state_field}, exp, "trigger outputs");
  endtask : trig

  // ===========================================
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    data_match_value = 32'h11223344;
    data_ignore_mask = 32'h00000000;
    num_errors = 0;
    compares = 0;
    cur_act = 2'h0;
    last_code = 4'h0;
    repeat (20) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    rd_chk(pbt_pkg::IDX_TRIGGER_SETUP, pbt_pkg::RST_TRIGGER_SETUP);
    rd_chk(pbt_pkg::IDX_PC_MATCH_VALUE, pbt_pkg::RST_PC_MATCH_VALUE);
    rd_chk(5'h1F, 32'h00000000);
    i_pbt_far_side.reg_write(1'b0, pbt_pkg::IDX_PC_MATCH_VALUE, 32'hA5A50000);
    rd_chk(pbt_pkg::IDX_PC_MATCH_VALUE, 32'hA5A50000);
    // both ports write in one cycle: the serial word must stay
    fork
      i_pbt_far_side.reg_write(1'b0, pbt_pkg::IDX_PC_MATCH_VALUE, 32'h0F0F0F0F);
      i_pbt_far_side.reg_write(1'b1, pbt_pkg::IDX_PC_MATCH_VALUE, 32'h5A5A5A5A);
    join
    rd_chk(pbt_pkg::IDX_PC_MATCH_VALUE, 32'h5A5A5A5A);
    i_pbt_far_side.load_pc(32'h0000000F, 32'h12345670);
    rd_chk(pbt_pkg::IDX_PC_IGNORE_MASK, 32'h00000000);
    rd_chk(pbt_pkg::IDX_PC_MATCH_VALUE, 32'h12345670);
    // armed level one on pc only, halt, reserved bits set
    setup(32'h4000E002);
    rd_chk(pbt_pkg::IDX_TRIGGER_SETUP, 32'h40002002);
    trig(32'h12345770, 1'b1, 32'h0, 1'b0, 2'h0, 2'h0, 1'b0, 4'h0);
    trig(32'h1234567F, 1'b1, 32'h0, 1'b0, 2'h0, 2'h0, 1'b1, 4'h1);
    trig(32'h12345670, 1'b1, 32'h0, 1'b0, 2'h0, 2'h0, 1'b0, 4'h1);
    // every response code, each write rearms and clears the state
    for (int a = 0; a < 4; a++)
    begin
      setup({a[1:0], 14'h0000, 16'h2002});
      trig(32'h00000000, 1'b1, 32'h0, 1'b0, 2'h0, 2'h0, 1'b0, 4'h0);
      trig(32'h12345675, 1'b1, 32'h0, 1'b0, 2'h0, 2'h0, 1'b1, 4'h1);
    end
    // armed without pc enable or lanes, then enabled but not armed
    setup(32'h00002000);
    trig(32'h12345670, 1'b1, 32'h11223344, 1'b1, 2'h0, 2'h0, 1'b0, 4'h0);
    setup(32'h00001002);
    trig(32'h12345670, 1'b1, 32'h11223344, 1'b1, 2'h0, 2'h0, 1'b0, 4'h0);
    // each data lane alone: miss with the lane data inverted, then hit
    for (int i = 0; i < 7; i++)
    begin
      setup(32'h00002000 | (32'h00000001 << lane_bit[i]));
      trig(32'h0, 1'b0, ~lane_dat[i], 1'b1, lane_sz[i], lane_al[i], 1'b0, 4'h0);
      trig(32'h0, 1'b0, lane_dat[i], 1'b1, lane_sz[i], lane_al[i], 1'b1, 4'h1);
    end
    // two levels: pc on level two, longword data on level one
    i_pbt_far_side.load_pc(32'h00000000, 32'h00001000);
    setup(32'h20023000);
    trig(32'h00001000, 1'b1, 32'h0, 1'b0, 2'h0, 2'h0, 1'b0, 4'h0);
    trig(32'h0, 1'b0, 32'h11223344, 1'b1, 2'h0, 2'h0, 1'b0, pbt_pkg::TSTAT_LEVEL1);
    trig(32'h00001000, 1'b1, 32'h0, 1'b0, 2'h0, 2'h0, 1'b1, pbt_pkg::TSTAT_LEVEL2);
    // level two alone with halt, then inverted pc and inverted data on level one
    setup(32'h60020000);
    trig(32'h00001000, 1'b1, 32'h0, 1'b0, 2'h0, 2'h0, 1'b1, pbt_pkg::TSTAT_LEVEL2);
    setup(32'h00002003);
    trig(32'h00001000, 1'b1, 32'h0, 1'b0, 2'h0, 2'h0, 1'b0, 4'h0);
    trig(32'h00002000, 1'b1, 32'h0, 1'b0, 2'h0, 2'h0, 1'b1, 4'h1);
    setup(32'h00003020);
    trig(32'h0, 1'b0, 32'h11223344, 1'b1, 2'h0, 2'h0, 1'b0, 4'h0);
    trig(32'h0, 1'b0, 32'h00000000, 1'b1, 2'h0, 2'h0, 1'b1, 4'h1);
    end_of_test();
  end
endmodule : tb
